//--- core/drb_pkg.sv
// package: register map, field layout, reset values and link states for the register bank
package drb_pkg;

    // register offsets, as carried in the command byte
    localparam logic [7:0] OFF_NO_OPERATION = 8'h00;
    localparam logic [7:0] OFF_IDENTITY     = 8'h01;
    localparam logic [7:0] OFF_UPDATE_MODE  = 8'h02;
    localparam logic [7:0] OFF_POWER_CTRL   = 8'h03;
    localparam logic [7:0] OFF_OUTPUT_SCALE = 8'h04;
    localparam logic [7:0] OFF_LOAD_STROBE  = 8'h05;
    localparam logic [7:0] OFF_FAULT_STATUS = 8'h07;
    localparam logic [7:0] OFF_OUTPUT_CODE  = 8'h08;

    // field positions
    localparam int BIT_SYNC_EN       = 0;
    localparam int BIT_REF_SHUTDOWN  = 8;
    localparam int BIT_OUT_SHUTDOWN  = 0;
    localparam int BIT_REF_DIVIDE    = 8;
    localparam int BIT_GAIN_DOUBLE   = 0;
    localparam int BIT_LOAD_STROBE   = 4;
    localparam int BIT_REF_FAULT     = 0;
    localparam int BIT_ID_SCALE      = 7;
    localparam int BIT_ID_RES_LSB    = 12;

    // values after reset
    localparam logic [15:0] RST_NO_OPERATION = 16'h0000;
    localparam logic       RST_SYNC_EN      = 1'b0;
    localparam logic       RST_REF_SHUTDOWN = 1'b0;
    localparam logic       RST_OUT_SHUTDOWN = 1'b0;
    localparam logic       RST_REF_DIVIDE   = 1'b0;
    localparam logic       RST_GAIN_DOUBLE  = 1'b1;
    localparam logic [15:0] CODE_ZERO_SCALE  = 16'h0000;
    localparam logic [15:0] CODE_MID_SCALE   = 16'h8000;

    // resolution codes of the identity register
    localparam logic [2:0] RES_16_BIT = 3'h0;
    localparam logic [2:0] RES_14_BIT = 3'h1;
    localparam logic [2:0] RES_12_BIT = 3'h2;
    localparam logic [15:0] MASK_16_BIT = 16'hFFFF;
    localparam logic [15:0] MASK_14_BIT = 16'hFFFC;
    localparam logic [15:0] MASK_12_BIT = 16'hFFF0;

    // two-wire link framing
    localparam logic [3:0] ADDR_PREFIX   = 4'h9;
    localparam logic [3:0] CNT_ACK_START = 4'h8;
    localparam logic [3:0] CNT_ACK_DONE  = 4'h9;
    localparam int         SYNC_WIDTH    = 5;

    // frame phases, gray coded along the write path
    typedef enum logic [2:0] {
        PH_IDLE     = 3'b000,
        PH_ADDR     = 3'b001,
        PH_CMD      = 3'b011,
        PH_UPPER    = 3'b010,
        PH_LOWER    = 3'b110,
        PH_RD_UPPER = 3'b111,
        PH_RD_LOWER = 3'b101,
        PH_IGNORE   = 3'b100
    } drb_phase_type;

    // controls handed to the analog stage
    typedef struct packed {
        logic [15:0] code;
        logic        out_shutdown;
        logic        ref_shutdown;
        logic        ref_divide;
        logic        gain_double;
        logic        force_zero;
    } drb_analog_type;

endpackage

//--- core/drb_sync2.sv
// two flip-flop synchroniser, one stage pair per bit
module drb_sync2
    import drb_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_reg[g] <= 1'b1;
                    sync_o[g]   <= 1'b1;
                end else begin
                    meta_reg[g] <= async_i[g];
                    sync_o[g]   <= meta_reg[g];
                end
            end
        end
    endgenerate
endmodule

//--- core/drb_register_bank.sv
// register bank and command decode behind the two-wire serial link
//
// What this block does
// (R1) A register write takes effect at the falling edge ending the lower-byte acknowledge.
// (R2) Command byte, then upper byte, then lower byte; the 16 bits go to the selected register.
// (R3) Offsets: 0 nop, 1 identity, 2 update mode, 3 power, 4 gain, 5 strobe, 7 status, 8 code.
// (R4) Output code is left aligned; low bits below the resolution read zero.
// (R5) No-operation register is write-only, resets to zero, and changes nothing.
// (R6) Identity is read-only; bits 14-12 give resolution code, bit 15 reads zero.
// (R7) Identity bit 7 reports the power-on scale: zero scale or midscale.
// (R8) With deferred update on, a new code waits for a load strobe.
// (R9) With deferred update off (default), a new code reaches the output at once.
// (R10) Update-mode register resets to zero; bit 0 is the enable, other bits reserved.
// (R11) Power bit 8 set disables the internal reference.
// (R12) Power bit 0 set powers the output down, pulled to ground.
// (R13) Gain bit 0 selects buffer gain two when set, one when clear; resets set, to gain two.
// (R14) A reference fault forces the output to zero but keeps the stored code.
// (R15) Writes to offset 6 or above 8 are ignored entirely.
// (R16) Status bit 0 shows the current reference fault, read-only.
module drb_register_bank
    import drb_pkg::*;
#(
    parameter logic [2:0] RESOLUTION = RES_16_BIT,
    parameter logic       MIDSCALE   = 1'b0,
    // arbitrary filler for the identity bits that carry no meaning here
    parameter logic [3:0] ID_FILL_HI = 4'h0,
    parameter logic [6:0] ID_FILL_LO = 7'h00
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           scl_i,
    input  wire logic           sda_i,
    output logic                sda_o,
    output logic                sda_oe_o,
    input  wire logic [1:0]     addr_sel_i,
    input  wire logic           ref_fault_i,
    output drb_analog_type      analog_o
);
    // synchronised link and pin levels
    logic [SYNC_WIDTH-1:0] pins_s;
    logic                  scl_s;
    logic                  sda_s;
    logic                  fault_s;
    logic [1:0]            addr_s;

    drb_sync2 #(
        .WIDTH (SYNC_WIDTH)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({addr_sel_i, ~ref_fault_i, sda_i, scl_i}),
        .sync_o  (pins_s)
    );

    assign scl_s   = pins_s[0];
    assign sda_s   = pins_s[1];
    // fault travels inverted so the idle-high synchroniser reset reads as no fault
    assign fault_s = ~pins_s[2];
    assign addr_s  = pins_s[4:3];

    // link state
    drb_phase_type phase_reg;
    drb_phase_type phase_next;
    logic          scl_d_reg;
    logic          sda_d_reg;
    logic [3:0]    cnt_reg;
    logic [8:0]    rx_reg;
    logic [7:0]    tx_reg;
    logic [7:0]    cmd_reg;
    logic [7:0]    upper_data_byte;
    logic          sda_oe_reg;

    // register state
    logic          sync_en_reg;
    logic          ref_shutdown_reg;
    logic          out_shutdown_reg;
    logic          ref_divide_reg;
    logic          gain_double_reg;
    logic [15:0]   pending_code_reg;
    logic [15:0]   active_code_reg;
    drb_analog_type analog_reg;

    // edges and conditions
    wire scl_rise  = scl_s & ~scl_d_reg;
    wire scl_fall  = ~scl_s & scl_d_reg;
    wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire active    = (phase_reg != PH_IDLE) && (phase_reg != PH_IGNORE);
    wire ack_start = scl_fall && (cnt_reg == CNT_ACK_START);
    wire ack_done  = scl_fall && (cnt_reg == CNT_ACK_DONE);
    wire [7:0] lower_data_byte = rx_reg[8:1];
    wire       host_ack        = ~rx_reg[0];
    wire       addr_match      = (rx_reg[8:5] == ADDR_PREFIX) && (rx_reg[4:2] == {1'b0, addr_s});
    // at the start of the acknowledge the address byte still sits one bit lower
    wire       ack_addr_ok     = (rx_reg[7:4] == ADDR_PREFIX) && (rx_reg[3:1] == {1'b0, addr_s});
    wire       addr_read       = rx_reg[1];
    wire       write_phase     = (phase_reg == PH_CMD) || (phase_reg == PH_UPPER)
                                 || (phase_reg == PH_LOWER);
    wire       rd_phase        = (phase_reg == PH_RD_UPPER) || (phase_reg == PH_RD_LOWER);
    wire       do_ack          = write_phase
                                 || ((phase_reg == PH_ADDR) && ack_addr_ok);

    // the 16-bit word of a write, committed only when the lower byte's acknowledge ends
    wire        commit     = ack_done && (phase_reg == PH_LOWER);       // [R1] [R2]
    wire [15:0] wdata      = {upper_data_byte, lower_data_byte};        // [R2]
    wire        wr_update  = commit && (cmd_reg == OFF_UPDATE_MODE);    // [R3]
    wire        wr_power   = commit && (cmd_reg == OFF_POWER_CTRL);     // [R3]
    wire        wr_gain    = commit && (cmd_reg == OFF_OUTPUT_SCALE);   // [R3]
    wire        wr_strobe  = commit && (cmd_reg == OFF_LOAD_STROBE);    // [R3]
    wire        wr_code    = commit && (cmd_reg == OFF_OUTPUT_CODE);    // [R3]
    // offsets 0, 1, 6, 7 and above 8 fall through: no register changes   [R5] [R15]
    wire        load_output_strobe = wr_strobe && wdata[BIT_LOAD_STROBE]; // [R8]

    // resolution mask keeps the code left aligned
    wire [15:0] res_mask = (RESOLUTION == RES_14_BIT) ? MASK_14_BIT :
                           (RESOLUTION == RES_12_BIT) ? MASK_12_BIT : MASK_16_BIT; // [R4]
    wire [15:0] code_in  = wdata & res_mask;                            // [R4]
    wire [15:0] code_rst = MIDSCALE ? (CODE_MID_SCALE & res_mask) : CODE_ZERO_SCALE;

    // read words: identity and status are read-only, the rest read back writable registers
    wire [15:0] identity_reg = {1'b0, RESOLUTION, ID_FILL_HI, MIDSCALE, ID_FILL_LO}; // [R6] [R7]
    wire [15:0] fault_status_reg = {15'h0000, fault_s};                 // [R16]
    wire [15:0] update_mode_rd  = {15'h0000, sync_en_reg};              // [R10]
    wire [15:0] power_rd        = {7'h00, ref_shutdown_reg, 7'h00, out_shutdown_reg};
    wire [15:0] gain_rd         = {7'h00, ref_divide_reg, 7'h00, gain_double_reg};

    // read selection; write-only and unused offsets read zero
    // code reads back pending, so a deferred code can be checked before its strobe
    wire [15:0] rd_word = (cmd_reg == OFF_IDENTITY)     ? identity_reg     :
                          (cmd_reg == OFF_UPDATE_MODE)  ? update_mode_rd   :
                          (cmd_reg == OFF_POWER_CTRL)   ? power_rd         :
                          (cmd_reg == OFF_OUTPUT_SCALE) ? gain_rd          :
                          (cmd_reg == OFF_FAULT_STATUS) ? fault_status_reg :
                          (cmd_reg == OFF_OUTPUT_CODE)  ? pending_code_reg : RST_NO_OPERATION;

    // phase sequencing at the end of each byte's acknowledge
    always_comb begin
        phase_next = phase_reg;
        if (start_det) begin
            phase_next = PH_ADDR;
        end else if (stop_det) begin
            phase_next = PH_IDLE;
        end else if (ack_done) begin
            case (phase_reg)
                PH_ADDR:     phase_next = !addr_match ? PH_IGNORE :
                                          addr_read ? PH_RD_UPPER : PH_CMD;
                PH_CMD:      phase_next = PH_UPPER;                     // [R2]
                PH_UPPER:    phase_next = PH_LOWER;                     // [R2]
                PH_LOWER:    phase_next = PH_UPPER;
                PH_RD_UPPER: phase_next = host_ack ? PH_RD_LOWER : PH_IGNORE;
                PH_RD_LOWER: phase_next = host_ack ? PH_RD_UPPER : PH_IGNORE;
                default:     phase_next = phase_reg;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= PH_IDLE;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            phase_reg <= phase_next;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // bit counter and receive shift, ninth bit is the acknowledge
    // counter clears at each start, so a repeated start mid-byte restarts cleanly
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 4'h0;
            rx_reg  <= 9'h000;
        end else if (start_det || ack_done) begin
            cnt_reg <= 4'h0;
        end else if (scl_rise && active) begin
            cnt_reg <= cnt_reg + 4'h1;
            rx_reg  <= {rx_reg[7:0], sda_s};
        end
    end

    // captured command and upper byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_reg         <= OFF_NO_OPERATION;
            upper_data_byte <= 8'h00;
        end else if (ack_done && (phase_reg == PH_CMD)) begin
            cmd_reg <= lower_data_byte;
        end else if (ack_done && (phase_reg == PH_UPPER)) begin
            upper_data_byte <= lower_data_byte;
        end
    end

    // open-drain data: enable pulls low, released otherwise and between frames
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_oe_reg <= 1'b0;
            tx_reg     <= 8'h00;
        end else if (start_det || stop_det) begin
            sda_oe_reg <= 1'b0;
        end else if (ack_start) begin
            sda_oe_reg <= do_ack;
        end else if (ack_done && (phase_next == PH_RD_UPPER)) begin
            sda_oe_reg <= ~rd_word[15];
            tx_reg     <= {rd_word[14:8], 1'b0};
        end else if (ack_done && (phase_next == PH_RD_LOWER)) begin
            sda_oe_reg <= ~rd_word[7];
            tx_reg     <= {rd_word[6:0], 1'b0};
        end else if (ack_done) begin
            sda_oe_reg <= 1'b0;
        end else if (scl_fall && rd_phase && (cnt_reg < CNT_ACK_START)) begin
            sda_oe_reg <= ~tx_reg[7];
            tx_reg     <= {tx_reg[6:0], 1'b0};
        end
    end

    // writable registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_en_reg      <= RST_SYNC_EN;                            // [R10]
            ref_shutdown_reg <= RST_REF_SHUTDOWN;
            out_shutdown_reg <= RST_OUT_SHUTDOWN;
            ref_divide_reg   <= RST_REF_DIVIDE;
            gain_double_reg  <= RST_GAIN_DOUBLE;                        // [R13]
        end else begin
            if (wr_update) begin
                sync_en_reg <= wdata[BIT_SYNC_EN];                      // [R10]
            end
            if (wr_power) begin
                ref_shutdown_reg <= wdata[BIT_REF_SHUTDOWN];            // [R11]
                out_shutdown_reg <= wdata[BIT_OUT_SHUTDOWN];            // [R12]
            end
            if (wr_gain) begin
                ref_divide_reg  <= wdata[BIT_REF_DIVIDE];
                gain_double_reg <= wdata[BIT_GAIN_DOUBLE];              // [R13]
            end
        end
    end

    // code path: pending holds the written code, active drives the output
    // a strobe with deferred update off does nothing: the output already matches
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pending_code_reg <= CODE_ZERO_SCALE;
            active_code_reg  <= CODE_ZERO_SCALE;
        end else if (wr_code) begin
            pending_code_reg <= code_in;
            if (!sync_en_reg) begin
                active_code_reg <= code_in;                             // [R9]
            end
        end else if (load_output_strobe && sync_en_reg) begin
            active_code_reg <= pending_code_reg;                        // [R8]
        end
    end

    // power-on scale is a parameter, so it is loaded once after reset release
    // limitation: active code resets to zero, so midscale stands for one cycle only
    logic init_done_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_done_reg <= 1'b0;
        end else begin
            init_done_reg <= 1'b1;
        end
    end

    // fault forces zero without touching the stored code
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_reg <= '{
                code:         CODE_ZERO_SCALE,
                out_shutdown: RST_OUT_SHUTDOWN,
                ref_shutdown: RST_REF_SHUTDOWN,
                ref_divide:   RST_REF_DIVIDE,
                gain_double:  RST_GAIN_DOUBLE,                          // [R13]
                force_zero:   1'b0
            };
        end else begin
            analog_reg.code         <= fault_s ? CODE_ZERO_SCALE :
                                       !init_done_reg ? code_rst : active_code_reg; // [R14]
            analog_reg.force_zero   <= fault_s;                         // [R14]
            analog_reg.out_shutdown <= out_shutdown_reg;                // [R12]
            analog_reg.ref_shutdown <= ref_shutdown_reg;                // [R11]
            analog_reg.ref_divide   <= ref_divide_reg;
            analog_reg.gain_double  <= gain_double_reg;                 // [R13]
        end
    end

    // open drain: the pin is only ever pulled low, the pull-up gives the one
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    assign sda_oe_o = sda_oe_reg;
    assign analog_o = analog_reg;
endmodule

//--- dv/drb_register_bank_props.sv
// checker: port timing relations of the register bank
module drb_register_bank_props
    import drb_pkg::*;
#(
    parameter logic [2:0] RESOLUTION = RES_16_BIT
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           scl_i,
    input  wire logic           sda_i,
    input  wire logic           sda_o,
    input  wire logic           sda_oe_o,
    input  wire logic [1:0]     addr_sel_i,
    input  wire logic           ref_fault_i,
    input  wire drb_analog_type analog_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] CODE_MASK = (RESOLUTION == RES_12_BIT) ? MASK_12_BIT :
                                        (RESOLUTION == RES_14_BIT) ? MASK_14_BIT : MASK_16_BIT;
    logic       scl_q;
    logic [3:0] fall_age;
    // cycles since the raw link clock fell; saturates so idle time never wraps
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q    <= 1'b1;
            fall_age <= 4'hF;
        end else begin
            scl_q    <= scl_i;
            fall_age <= (scl_q && !scl_i) ? 4'h0 : ((fall_age == 4'hF) ? 4'hF : fall_age + 4'h1);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_fault_steady;
        (ref_fault_i == $past(ref_fault_i))[*6];
    endsequence
    sequence s_scl_high_hold;
        $rose(scl_i) ##1 scl_i[*3];
    endsequence
    a_code_aligned: assert property (analog_o.code == (analog_o.code & CODE_MASK))
        else $error("output code has bits below the resolution");
    a_commit_after_fall: assert property ($changed(analog_o.code) && !analog_o.force_zero
        && !$past(analog_o.force_zero) && !$past(analog_o.force_zero, 2)
        && !$past(analog_o.force_zero, 3) |-> fall_age <= 4'h8)
        else $error("output code moved away from a link clock fall");
    a_ctrl_after_fall: assert property ($changed({analog_o.out_shutdown,
        analog_o.ref_shutdown, analog_o.gain_double}) |-> fall_age <= 4'h8)
        else $error("control bit moved away from a link clock fall");
    a_fault_zero_code: assert property (analog_o.force_zero && $past(analog_o.force_zero)
        |-> analog_o.code == 16'h0000)
        else $error("output code not zero during fault");
    a_fault_tracks_pin: assert property (s_fault_steady
        |-> analog_o.force_zero == ref_fault_i)
        else $error("fault force does not follow the fault input");
    a_ack_in_low: assert property ($rose(sda_oe_o) |-> !scl_i && fall_age <= 4'h6)
        else $error("data drive started outside the clock low phase");
    a_release_on_fall: assert property ($fell(sda_oe_o) |-> scl_i || fall_age <= 4'h6)
        else $error("data drive released at an odd moment");
    a_oe_steady_high: assert property (s_scl_high_hold |-> $stable(sda_oe_o))
        else $error("data drive changed while the clock was high");
    a_drive_low_only: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("data line driven high");
endmodule

bind drb_register_bank drb_register_bank_props #(.RESOLUTION(RESOLUTION)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .ref_fault_i(ref_fault_i),
    .analog_o(analog_o)
);

//--- dv/drb_host_model.sv
// two-wire host model: drives the link clock and pulls the data line low
module drb_host_model (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    // one bit, 48 ns; data set mid low phase, sampled mid high phase
    task automatic bit_cyc(input logic drv_low, output logic seen);
        sda_low_o = drv_low;
        #12 scl_o = 1'b1;
        #12 seen = sda_i;
        #12 scl_o = 1'b0;
        #12;
    endtask
    task automatic start_cond();
        sda_low_o = 1'b0;
        #12 scl_o = 1'b1;
        #12 sda_low_o = 1'b1;
        #12 scl_o = 1'b0;
        #12;
    endtask
    // clock is left high afterwards: it stands still between frames
    task automatic stop_cond();
        sda_low_o = 1'b1;
        #12 scl_o = 1'b1;
        #12 sda_low_o = 1'b0;
        #12;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(!b[i], s);
        end
        bit_cyc(1'b0, s);
        ack = !s;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b0, b[i]);
        end
        bit_cyc(!last, s);
    endtask
    task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                             output logic ok);
        logic [3:0] k;
        start_cond();
        send_byte({a, 1'b0}, k[3]);
        send_byte(c, k[2]); // command, upper byte, lower byte
        send_byte(d[15:8], k[1]);
        send_byte(d[7:0], k[0]);
        stop_cond();
        ok = &k;
    endtask
    task automatic read_reg(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d);
        logic k;
        start_cond();
        send_byte({a, 1'b0}, k);
        send_byte(c, k);
        start_cond();
        send_byte({a, 1'b1}, k);
        recv_byte(1'b0, d[15:8]);
        recv_byte(1'b1, d[7:0]);
        stop_cond();
    endtask
endmodule

//--- dv/tb_top.sv
// testbench: register bank driven by the two-wire host model
module tb_top
    import drb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic           clk_i;
    logic           rst_i;
    logic           scl_w;
    logic           sda_low;
    logic           sda_o;
    logic           sda_oe_o;
    logic [1:0]     addr_sel_i;
    logic           ref_fault_i;
    drb_analog_type analog_o;
    wire logic      sda_w = !(sda_low || sda_oe_o); // open drain with pull-up
    int             err_total;
    int             cmp_count;
    int             cyc;
    logic           ok;
    logic [6:0]     dev_addr;
    logic [15:0]    rd_val;
    logic [15:0]    last_code;
    logic [15:0]    nxt;
    logic [7:0]     ign_off [5] = '{OFF_NO_OPERATION, OFF_IDENTITY, 8'h06, OFF_FAULT_STATUS,
                                    8'h09};

    drb_register_bank #(.RESOLUTION(RES_14_BIT)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .ref_fault_i(ref_fault_i),
        .analog_o(analog_o)
    );
    drb_host_model host (.sda_i(sda_w), .scl_o(scl_w), .sda_low_o(sda_low));

    initial clk_i = 1'b0;
    always #2 clk_i = !clk_i;
    // whole run is near 14000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.write_reg(dev_addr, c, d, ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        host.read_reg(dev_addr, c, rd_val);
        chk(rd_val, exp);
    endtask
    task automatic settle();
        repeat (10) @(negedge clk_i);
    endtask
    function automatic logic [15:0] id_exp();
        return {1'b0, RES_14_BIT, 4'h0, 1'b0, 7'h00};
    endfunction
    function automatic logic [15:0] code_exp(input logic [15:0] d);
        return d & MASK_14_BIT;
    endfunction

    initial begin
        rst_i       = 1'b1;
        addr_sel_i  = 2'h0;
        ref_fault_i = 1'b0;
        void'($urandom(4993));
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst_i      = 1'b0;
        addr_sel_i = 2'($urandom);
        dev_addr   = {ADDR_PREFIX, 1'b0, addr_sel_i};
        settle();
        chk({15'h0000, analog_o.gain_double}, 16'h0001);
        chk(analog_o.code, CODE_ZERO_SCALE);
        rd(OFF_IDENTITY, id_exp());
        rd(OFF_UPDATE_MODE, 16'h0000);
        rd(OFF_OUTPUT_SCALE, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            nxt = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(OFF_OUTPUT_CODE, nxt);
            last_code = code_exp(nxt);
            chk(analog_o.code, last_code);
        end
        foreach (ign_off[i]) begin
            wr(ign_off[i], 16'($urandom));
            chk(analog_o.code, last_code);
        end
        rd(OFF_IDENTITY, id_exp());
        wr(OFF_UPDATE_MODE, 16'hFFFF);
        rd(OFF_UPDATE_MODE, 16'h0001);
        nxt = ~last_code;
        wr(OFF_OUTPUT_CODE, nxt);
        chk(analog_o.code, last_code);
        wr(OFF_LOAD_STROBE, 16'h0010);
        last_code = code_exp(nxt);
        chk(analog_o.code, last_code);
        wr(OFF_UPDATE_MODE, 16'h0000);
        wr(OFF_POWER_CTRL, 16'h0101);
        chk({14'h0000, analog_o.ref_shutdown, analog_o.out_shutdown}, 16'h0003);
        rd(OFF_POWER_CTRL, 16'h0101);
        wr(OFF_POWER_CTRL, 16'h0000);
        wr(OFF_OUTPUT_SCALE, 16'h0100);
        chk({14'h0000, analog_o.ref_divide, analog_o.gain_double}, 16'h0002);
        rd(OFF_OUTPUT_SCALE, 16'h0100);
        @(negedge clk_i);
        ref_fault_i = 1'b1;
        settle();
        chk(analog_o.code, 16'h0000);
        chk({14'h0000, sda_o, analog_o.force_zero}, 16'h0001);
        rd(OFF_FAULT_STATUS, 16'h0001);
        @(negedge clk_i);
        ref_fault_i = 1'b0;
        settle();
        chk(analog_o.code, last_code);
        rd(OFF_FAULT_STATUS, 16'h0000);
        // a foreign address must be neither acknowledged nor applied
        host.write_reg(dev_addr ^ 7'h01, OFF_OUTPUT_CODE, 16'h0000, ok);
        chk({15'h0000, ok}, 16'h0000);
        chk(analog_o.code, last_code);
        wr(OFF_UPDATE_MODE, 16'h0001);
        @(negedge clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        settle();
        chk({14'h0000, analog_o.ref_divide, analog_o.gain_double}, 16'h0001);
        chk(analog_o.code, CODE_ZERO_SCALE);
        rd(OFF_UPDATE_MODE, 16'h0000);
        complete_run();
    end
endmodule
